// file: ebtc_cfg.svh
// Purpose: Bus timing unit constants
// Assumes: Byte offsets
// Notes:   Shared by all modules except ebtc_ext_mem
`ifndef EBTC_CFG_SVH
`define EBTC_CFG_SVH

`define EBTC_GEN_CTRL_OFFSET   8'h00
`define EBTC_TIM_CTRL_OFFSET   8'h04
`define EBTC_CMD_ADDR_OFFSET   8'h08
`define EBTC_CMD_DATA_OFFSET   8'h0C
`define EBTC_STATUS_OFFSET     8'h10

`define EBTC_GEN_RESET         32'h0000_0000
`define EBTC_TIM_RESET         32'h0000_0000
`define EBTC_GEN_MASK          32'h0007_0703
`define EBTC_TIM_MASK          32'h0F00_F7F8

`define EBTC_EN_BIT            0
`define EBTC_W16_BIT           1
`define EBTC_DIV_LSB           8
`define EBTC_ALE_LSB           16
`define EBTC_ACC_LSB           3
`define EBTC_AHD_LSB           8
`define EBTC_IW2X_LSB          12
`define EBTC_IR2R_LSB          24

`define EBTC_DIV_BY4           3'h2
`define EBTC_DIV_BY8           3'h3
`define EBTC_DIV_BY16          3'h4
`define EBTC_DIV_BY32          3'h5
`define EBTC_DIV_BY2           3'h1

`define EBTC_ADDR_SETUP_CLKS   6'h01
`define EBTC_LATCH_HOLD_CLKS   6'h01
`define EBTC_TURNAROUND_CLKS   6'h01

`endif

// file: ebtc_pkg.sv
// Purpose: Types shared by the bus timing unit
// Assumes: Constants come from ebtc_cfg.svh
// Notes:   One-hot state codes written out
package ebtc_pkg;

    typedef enum logic [7:0]
    {
        ST_IDLE  = 8'h01,
        ST_SETUP = 8'h02,
        ST_LATCH = 8'h04,
        ST_LHOLD = 8'h08,
        ST_TURN  = 8'h10,
        ST_ACC   = 8'h20,
        ST_HOLD  = 8'h40,
        ST_GAP   = 8'h80
    } ebtc_state_type;

    typedef struct packed
    {
        logic        write;
        logic [15:0] addr;
        logic [15:0] data;
    } ebtc_cmd_type;

    typedef struct packed
    {
        logic        chip_select_n;
        logic        ale;
        logic        read_strobe_n;
        logic        write_strobe_n;
        logic [15:0] ad_out;
        logic [15:0] ad_oe_n;
    } ebtc_pins_type;

endpackage

// file: ebtc_clkdiv.sv
// Purpose: Interface clock tick
// Assumes: Code from general control
// Notes:   Tick ends each period
`timescale 1ns/1ps
`include "ebtc_cfg.svh"

module ebtc_clkdiv
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] iface_clock_divider,
    output logic            tick,
    output logic            undivided
);

    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic [4:0] limit;

    // ************************************************************
    // Divider decode
    // ************************************************************
    // RULE1: divide code decode
    // RULE2: codes 000 and 001
    always_comb
    begin
        case (iface_clock_divider)
            `EBTC_DIV_BY2:  limit = 5'h01;
            `EBTC_DIV_BY4:  limit = 5'h03;
            `EBTC_DIV_BY8:  limit = 5'h07;
            `EBTC_DIV_BY16: limit = 5'h0F;
            `EBTC_DIV_BY32: limit = 5'h1F;
            default:        limit = 5'h00;
        endcase
    end

    assign undivided = (limit == 5'h00);
    assign nxt_cnt   = (cnt_ff >= limit) ? 5'h00 : cnt_ff + 5'h01;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= 5'h00;
        else
            cnt_ff <= nxt_cnt;
    end

    // Tick at end of each interface period
    assign tick = (cnt_ff >= limit);

endmodule

// file: ebtc_top.sv
// What this block does
// RULE1: Divider codes select divide by 4 to 32
// RULE2: Codes 000 undivided, 001 divide by two
// RULE3: Undivided launches rising, divided launches falling
// RULE4: Width bit one selects 16-bit bus
// RULE5: 8-bit mode keeps address on upper lines
// RULE6: Accesses run only while enable set; code only gates the start, an access under way runs to completion
// RULE7: Setup, latch width, latch hold, turnaround, strobe
// RULE8: Strobe lasts access field plus one
// RULE9: Hold lasts hold field plus one
// RULE10: Read-read idle cycles from field value
// RULE11: After-write idle cycles from field value
// RULE12: Idle cycles keep controls inactive
// RULE13: Timing register resets to zero
// Purpose: Multiplexed external bus with programmable timing
// Assumes: Accesses start by command register
// Notes:   Pins timed in interface clocks
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "ebtc_cfg.svh"

module ebtc_top
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_write,
    input  wire logic          reg_read,
    output logic [31:0]        reg_rdata,
    output logic               chip_select_n,
    output logic               ale,
    output logic               read_strobe_n,
    output logic               write_strobe_n,
    output logic [15:0]        ad_out,
    output logic [15:0]        ad_oe_n,
    input  wire logic [15:0]   ad_in
);

    logic [31:0]                 bus_general_control_ff;
    logic [31:0]                 bus_timing_control_ff;
    ebtc_pkg::ebtc_cmd_type      cmd_ff;
    logic                        pend_ff;
    logic                        last_read_ff;
    logic [15:0]                 rdata_ff;
    logic [31:0]                 reg_rdata_ff;
    logic [15:0]                 ad_s1_ff;
    logic [15:0]                 ad_s2_ff;
    ebtc_pkg::ebtc_state_type    state_ff;
    ebtc_pkg::ebtc_state_type    nxt_state;
    logic [5:0]                  cnt_ff;
    logic [5:0]                  nxt_cnt;
    ebtc_pkg::ebtc_pins_type     pins_ff;
    ebtc_pkg::ebtc_pins_type     nxt_pins;
    ebtc_pkg::ebtc_pins_type     pins_neg_ff;
    logic                        tick;
    logic                        undivided;
    logic                        bus_function_enable;
    logic                        wide_bus_select;
    logic [2:0]                  latch_strobe_width_field;
    logic [4:0]                  access_time_field;
    logic [2:0]                  hold_time_field;
    logic [3:0]                  post_write_idle_count;
    logic [3:0]                  read_read_idle_count;
    logic                        busy;
    logic                        start;
    logic [5:0]                  gap_len;

    assign bus_function_enable      = bus_general_control_ff[`EBTC_EN_BIT];
    assign wide_bus_select          = bus_general_control_ff[`EBTC_W16_BIT];
    assign latch_strobe_width_field = bus_general_control_ff[`EBTC_ALE_LSB +: 3];
    assign access_time_field        = bus_timing_control_ff[`EBTC_ACC_LSB +: 5];
    assign hold_time_field          = bus_timing_control_ff[`EBTC_AHD_LSB +: 3];
    assign post_write_idle_count    = bus_timing_control_ff[`EBTC_IW2X_LSB +: 4];
    assign read_read_idle_count     = bus_timing_control_ff[`EBTC_IR2R_LSB +: 4];
    assign busy                     = pend_ff || (state_ff != ebtc_pkg::ST_IDLE && state_ff != ebtc_pkg::ST_GAP);

    // Field plus one as a cycle count
    function automatic logic [5:0] plus_one(input logic [4:0] f);
        plus_one = {1'b0, f} + 6'h01;
    endfunction

    // ************************************************************
    // Interface clock
    // ************************************************************
    ebtc_clkdiv u_clkdiv
    (
        .clk                 (clk),
        .rst                 (rst),
        .iface_clock_divider (bus_general_control_ff[`EBTC_DIV_LSB +: 3]),
        .tick                (tick),
        .undivided           (undivided)
    );

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bus_general_control_ff <= `EBTC_GEN_RESET;
        else if (reg_write && reg_addr == `EBTC_GEN_CTRL_OFFSET)
            bus_general_control_ff <= reg_wdata & `EBTC_GEN_MASK;
    end

    // RULE13: timing reset zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bus_timing_control_ff <= `EBTC_TIM_RESET;
        else if (reg_write && reg_addr == `EBTC_TIM_CTRL_OFFSET)
            bus_timing_control_ff <= reg_wdata & `EBTC_TIM_MASK;
    end

    // Command capture, ignored while busy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cmd_ff <= '0;
        else if (reg_write && !busy && reg_addr == `EBTC_CMD_ADDR_OFFSET)
            {cmd_ff.write, cmd_ff.addr} <= {reg_wdata[31], reg_wdata[15:0]};
        else if (reg_write && !busy && reg_addr == `EBTC_CMD_DATA_OFFSET)
            cmd_ff.data <= reg_wdata[15:0];
    end

    // RULE6: start gated by enable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pend_ff <= 1'b0;
        else if (!bus_function_enable)
            pend_ff <= 1'b0;
        else if (reg_write && !busy && reg_addr == `EBTC_CMD_ADDR_OFFSET)
            pend_ff <= 1'b1;
        else if (start)
            pend_ff <= 1'b0;
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata_ff <= 32'h0000_0000;
        else if (!reg_read)
            reg_rdata_ff <= 32'h0000_0000;
        else if (reg_addr == `EBTC_GEN_CTRL_OFFSET)
            reg_rdata_ff <= bus_general_control_ff;
        else if (reg_addr == `EBTC_TIM_CTRL_OFFSET)
            reg_rdata_ff <= bus_timing_control_ff;
        else if (reg_addr == `EBTC_CMD_ADDR_OFFSET)
            reg_rdata_ff <= {cmd_ff.write, 15'h0000, cmd_ff.addr};
        else if (reg_addr == `EBTC_CMD_DATA_OFFSET)
            reg_rdata_ff <= {16'h0000, rdata_ff};
        else if (reg_addr == `EBTC_STATUS_OFFSET)
            reg_rdata_ff <= {31'h0000_0000, busy};
        else
            reg_rdata_ff <= 32'h0000_0000;
    end

    assign reg_rdata = reg_rdata_ff;

    // ************************************************************
    // Pin input synchroniser
    // ************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            {ad_s2_ff, ad_s1_ff} <= 32'h0000_0000;
        else
            {ad_s2_ff, ad_s1_ff} <= {ad_s1_ff, ad_in};
    end

    // ************************************************************
    // Access sequencer
    // ************************************************************
    assign start   = tick && pend_ff && (state_ff == ebtc_pkg::ST_IDLE);
    assign gap_len = cmd_ff.write ? {2'b00, post_write_idle_count} : {2'b00, read_read_idle_count};

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        if (tick)
        begin
            case (state_ff)
                ebtc_pkg::ST_IDLE:
                begin
                    if (pend_ff)
                    begin
                        // RULE7: one clock address setup
                        nxt_state = ebtc_pkg::ST_SETUP;
                        nxt_cnt   = `EBTC_ADDR_SETUP_CLKS;
                    end
                end
                ebtc_pkg::ST_SETUP:
                begin
                    nxt_state = ebtc_pkg::ST_LATCH;
                    nxt_cnt   = plus_one({2'b00, latch_strobe_width_field});
                end
                ebtc_pkg::ST_LATCH:
                begin
                    if (cnt_ff <= 6'h01)
                    begin
                        nxt_state = ebtc_pkg::ST_LHOLD;
                        nxt_cnt   = `EBTC_LATCH_HOLD_CLKS;
                    end
                    else
                        nxt_cnt = cnt_ff - 6'h01;
                end
                ebtc_pkg::ST_LHOLD:
                begin
                    nxt_state = ebtc_pkg::ST_TURN;
                    nxt_cnt   = `EBTC_TURNAROUND_CLKS;
                end
                ebtc_pkg::ST_TURN:
                begin
                    // RULE8: access field plus one
                    nxt_state = ebtc_pkg::ST_ACC;
                    nxt_cnt   = plus_one(access_time_field);
                end
                ebtc_pkg::ST_ACC:
                begin
                    if (cnt_ff <= 6'h01)
                    begin
                        // RULE9: hold field plus one
                        nxt_state = ebtc_pkg::ST_HOLD;
                        nxt_cnt   = plus_one({2'b00, hold_time_field});
                    end
                    else
                        nxt_cnt = cnt_ff - 6'h01;
                end
                ebtc_pkg::ST_HOLD:
                begin
                    if (cnt_ff > 6'h01)
                        nxt_cnt = cnt_ff - 6'h01;
                    // RULE10: read-read idle
                    // RULE11: after-write idle
                    else if (gap_len != 6'h00)
                    begin
                        nxt_state = ebtc_pkg::ST_GAP;
                        nxt_cnt   = gap_len;
                    end
                    else
                        nxt_state = ebtc_pkg::ST_IDLE;
                end
                ebtc_pkg::ST_GAP:
                begin
                    // Read gap cut only by a pending write
                    if (cnt_ff <= 6'h01 || (last_read_ff && pend_ff && cmd_ff.write))
                        nxt_state = ebtc_pkg::ST_IDLE;
                    else
                        nxt_cnt = cnt_ff - 6'h01;
                end
                default:
                    nxt_state = ebtc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ebtc_pkg::ST_IDLE;
            cnt_ff   <= 6'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Kind of completed access
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            last_read_ff <= 1'b0;
        else if (tick && state_ff == ebtc_pkg::ST_HOLD)
            last_read_ff <= !cmd_ff.write;
    end
    // Read data sampled at strobe release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_ff <= 16'h0000;
        else if (tick && state_ff == ebtc_pkg::ST_ACC && cnt_ff <= 6'h01 && !cmd_ff.write)
            rdata_ff <= wide_bus_select ? ad_s2_ff : {8'h00, ad_s2_ff[7:0]};
    end

    // ************************************************************
    // Pin values
    // ************************************************************
    always_comb
    begin
        nxt_pins.chip_select_n  = 1'b1;
        nxt_pins.ale            = 1'b0;
        nxt_pins.read_strobe_n  = 1'b1;
        nxt_pins.write_strobe_n = 1'b1;
        nxt_pins.ad_out         = 16'h0000;
        nxt_pins.ad_oe_n        = 16'hFFFF;
        // RULE12: idle keeps controls inactive
        if (nxt_state != ebtc_pkg::ST_IDLE && nxt_state != ebtc_pkg::ST_GAP)
        begin
            nxt_pins.chip_select_n  = 1'b0;
            nxt_pins.ale            = (nxt_state == ebtc_pkg::ST_LATCH);
            nxt_pins.read_strobe_n  = !(nxt_state == ebtc_pkg::ST_ACC && !cmd_ff.write);
            nxt_pins.write_strobe_n = !(nxt_state == ebtc_pkg::ST_ACC && cmd_ff.write);
            nxt_pins.ad_oe_n        = 16'h0000;
            nxt_pins.ad_out         = cmd_ff.addr;
            // RULE4: data width select
            if (nxt_state == ebtc_pkg::ST_TURN || nxt_state == ebtc_pkg::ST_ACC || nxt_state == ebtc_pkg::ST_HOLD)
            begin
                if (wide_bus_select)
                begin
                    nxt_pins.ad_out  = cmd_ff.data;
                    nxt_pins.ad_oe_n = cmd_ff.write ? 16'h0000 : 16'hFFFF;
                end
                else
                begin
                    // RULE5: upper lines keep address
                    nxt_pins.ad_out  = {cmd_ff.addr[15:8], cmd_ff.data[7:0]};
                    nxt_pins.ad_oe_n = cmd_ff.write ? 16'h0000 : 16'h00FF;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pins_ff <= '{1'b1, 1'b0, 1'b1, 1'b1, 16'h0000, 16'hFFFF};
        else
            pins_ff <= nxt_pins;
    end

    // RULE3: falling launch when divided
    always_ff @(negedge clk or posedge rst)
    begin
        if (rst)
            pins_neg_ff <= '{1'b1, 1'b0, 1'b1, 1'b1, 16'h0000, 16'hFFFF};
        else
            pins_neg_ff <= pins_ff;
    end

    assign {chip_select_n, ale, read_strobe_n, write_strobe_n, ad_out, ad_oe_n} = undivided ? pins_ff : pins_neg_ff;

endmodule

// file: ebtc_top_properties.sv
// Purpose: Pin timing checks
// Assumes: Control writes always land
// Notes:   Times in system clocks
`timescale 1ns/1ps
`include "ebtc_cfg.svh"

module ebtc_top_checker
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        chip_select_n,
    input wire logic        ale,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [15:0] ad_out,
    input wire logic [15:0] ad_oe_n,
    input wire logic [15:0] ad_in
);
    logic [31:0] gen_ff;
    logic [31:0] tim_ff;
    logic [10:0] stb_cnt_ff;
    logic [10:0] hold_cnt_ff;
    logic [10:0] gap_cnt_ff;
    logic        cs_q_ff;
    logic        last_wr_ff;
    logic        last_rd_ff;
    logic        stb_n;
    logic [10:0] t_len;
    logic        cfg_wr;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    assign stb_n  = read_strobe_n & write_strobe_n;
    assign t_len  = (gen_ff[10:8] <= 3'h5) ? (11'h001 << gen_ff[10:8]) : 11'h001;
    assign cfg_wr = reg_write && (reg_addr == `EBTC_GEN_CTRL_OFFSET || reg_addr == `EBTC_TIM_CTRL_OFFSET);

    // ***********************************
    // Shadow registers and counters
    // ***********************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gen_ff <= `EBTC_GEN_RESET;
            tim_ff <= `EBTC_TIM_RESET;
        end
        else if (reg_write && reg_addr == `EBTC_GEN_CTRL_OFFSET)
            gen_ff <= reg_wdata & `EBTC_GEN_MASK;
        else if (reg_write && reg_addr == `EBTC_TIM_CTRL_OFFSET)
            tim_ff <= reg_wdata & `EBTC_TIM_MASK;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stb_cnt_ff  <= 11'h000;
            hold_cnt_ff <= 11'h000;
            gap_cnt_ff  <= 11'h000;
            cs_q_ff     <= 1'h1;
        end
        else
        begin
            stb_cnt_ff  <= stb_n ? 11'h000 : stb_cnt_ff + 11'h001;
            hold_cnt_ff <= (chip_select_n || !stb_n) ? 11'h000 : hold_cnt_ff + 11'h001;
            cs_q_ff     <= chip_select_n;
            if (chip_select_n)
                gap_cnt_ff <= !cs_q_ff ? 11'h001 : (gap_cnt_ff == 11'h7FF ? gap_cnt_ff : gap_cnt_ff + 11'h001);
        end
    end

    // Last access kind
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst || cfg_wr)
        begin
            last_wr_ff <= 1'h0;
            last_rd_ff <= 1'h0;
        end
        else if (!write_strobe_n || !read_strobe_n)
        begin
            last_wr_ff <= !write_strobe_n;
            last_rd_ff <= !read_strobe_n;
        end
    end

    // ***********************************
    // Assertions
    // ***********************************
    AST_TIM_READBACK: assert property (reg_read && reg_addr == `EBTC_TIM_CTRL_OFFSET |=> reg_rdata == $past(tim_ff))
        else $error("timing register read back wrong");
    AST_ENABLE_GATES: assert property ($fell(chip_select_n) |-> gen_ff[0])
        else $error("access started while disabled");
    AST_IDLE_QUIET: assert property (chip_select_n |-> !ale && stb_n)
        else $error("control active while deselected");
    AST_ONE_STROBE: assert property (!read_strobe_n |-> write_strobe_n)
        else $error("both strobes active");
    AST_SETUP_BEFORE_LATCH: assert property ($rose(ale) |-> $past(chip_select_n) == 1'h0)
        else $error("no select setup before latch");
    AST_LATCH_TO_STROBE: assert property ($fell(ale) |-> stb_n [*2])
        else $error("strobe too soon after latch");
    AST_ACCESS_WIDTH: assert property ($rose(stb_n) |-> stb_cnt_ff == (11'(tim_ff[7:3]) + 11'h001) * t_len)
        else $error("strobe width wrong");
    AST_HOLD_WIDTH: assert property ($rose(chip_select_n) |-> hold_cnt_ff == (11'(tim_ff[10:8]) + 11'h001) * t_len)
        else $error("hold time wrong");
    AST_WRITE_GAP: assert property ($fell(stb_n) && last_wr_ff |-> gap_cnt_ff >= 11'(tim_ff[15:12]) * t_len)
        else $error("idle after write too short");
    AST_READ_GAP: assert property ($fell(read_strobe_n) && last_rd_ff |-> gap_cnt_ff >= 11'(tim_ff[27:24]) * t_len)
        else $error("idle between reads too short");
    AST_NARROW_UPPER: assert property (!chip_select_n && !cs_q_ff && !gen_ff[1] |-> $stable(ad_out[15:8]) && ad_oe_n[15:8] == 8'h00)
        else $error("upper lines not holding address");
    AST_WIDE_DRIVE: assert property (!write_strobe_n && gen_ff[1] |-> ad_oe_n == 16'h0000)
        else $error("wide write not driving all lines");

    COV_WRITE: cover property ($fell(write_strobe_n));
    COV_READ: cover property ($fell(read_strobe_n) && last_rd_ff);
    COV_SLOWEST: cover property ($fell(chip_select_n) && gen_ff[10:8] == 3'h5);
endmodule

bind ebtc_top ebtc_top_checker i_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .chip_select_n(chip_select_n), .ale(ale),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in));

// file: ebtc_ext_mem.sv
// Purpose: External memory model
// Assumes: 256 words
// Notes:   Released lines invert; slow answers late
`timescale 1ns/1ps

module ebtc_ext_mem
(
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        chip_select_n,
    input  wire logic        ale,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [15:0] ad_out,
    input  wire logic [15:0] ad_oe_n,
    output logic      [15:0] ad_in,
    output logic      [15:0] lat_addr
);
    logic [15:0] mem [0:255];
    logic [15:0] last_ff = 16'hA5A5;
    logic [3:0]  rcnt_ff = 4'h0;
    logic        drive;
    logic [15:0] far;

    always_ff @(posedge clk)
    begin
        if (ale && !chip_select_n)
            lat_addr <= ad_out;
        if (!write_strobe_n && !chip_select_n)
            mem[lat_addr[7:0]] <= ad_out;
        rcnt_ff <= read_strobe_n ? 4'h0 : (rcnt_ff == 4'hF ? rcnt_ff : rcnt_ff + 4'h1);
        last_ff <= ad_in;
    end

    assign drive = !read_strobe_n && !chip_select_n && (!slow || rcnt_ff >= 4'h8);
    assign far   = drive ? mem[lat_addr[7:0]] : ~last_ff;
    assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & far);
endmodule

// file: ebtc_top_tb_top.sv
// Purpose: Register and bus tests
// Assumes: Command bit 31 selects write
// Notes:   Each divider code: write, two reads
`timescale 1ns/1ps
`include "ebtc_cfg.svh"

module ebtc_top_tb_top;
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic        chip_select_n;
    logic        ale;
    logic        read_strobe_n;
    logic        write_strobe_n;
    logic [15:0] ad_out;
    logic [15:0] ad_oe_n;
    logic [15:0] ad_in;
    logic [15:0] lat_addr;
    logic        slow;
    logic        cs_lvl;
    logic [31:0] v;
    logic [15:0] a;
    logic [15:0] d;
    int          error_cnt;
    int          checks_done;
    int          cyc;
    int          cs_falls;
    logic [31:0] cfg_gen [8] = '{32'h0000_0003, 32'h0000_0101, 32'h0002_0203, 32'h0000_0301,
                                 32'h0000_0403, 32'h0007_0501, 32'h0000_0603, 32'h0000_0701};
    logic [31:0] cfg_tim [8] = '{32'h0000_0010, 32'h0300_2118, 32'h0100_1210, 32'h0200_3010,
                                 32'h0000_0010, 32'h0F00_F7F8, 32'h0F00_F010, 32'h0000_0010};

    ebtc_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .chip_select_n(chip_select_n), .ale(ale),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .ad_in(ad_in));
    ebtc_ext_mem i_mem (.clk(clk), .slow(slow), .chip_select_n(chip_select_n), .ale(ale),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .ad_in(ad_in), .lat_addr(lat_addr));

    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // ***********************************
    // Access tasks
    // ***********************************
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= dat;
        reg_write <= 1'h1;
        @(posedge clk);
        reg_write <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] dat);
        @(posedge clk);
        reg_addr <= ad;
        reg_read <= 1'h1;
        @(posedge clk);
        reg_read <= 1'h0;
        #1 dat = reg_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] got;
        rd(ad, got);
        chk(got, exp);
    endtask

    task automatic access(input logic w, input logic [15:0] ad, input logic [15:0] dat);
        logic [31:0] s;
        if (w)
            wr(`EBTC_CMD_DATA_OFFSET, {16'h0000, dat});
        wr(`EBTC_CMD_ADDR_OFFSET, {w, 15'h0000, ad});
        do
            rd(`EBTC_STATUS_OFFSET, s);
        while (s[0] !== 1'h0);
    endtask

    always @(negedge chip_select_n)
    begin
        cs_falls++;
        cs_lvl = clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t run too long", $time);
            finish_test();
        end
    end

    // ***********************************
    // Test sequence
    // ***********************************
    initial
    begin
        rst = 1'h1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_write = 1'h0;
        reg_read = 1'h0;
        slow = 1'h0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd_chk(`EBTC_TIM_CTRL_OFFSET, 32'h0000_0000);
        access(1'h1, 16'h0042, 16'h1234);
        repeat (50) @(posedge clk);
        chk(32'(cs_falls), 32'h0000_0000);
        wr(`EBTC_TIM_CTRL_OFFSET, 32'hFFFF_FFFF);
        rd_chk(`EBTC_TIM_CTRL_OFFSET, 32'h0F00_F7F8);
        rd_chk(8'h14, 32'h0000_0000);
        for (int i = 0; i < 8; i++)
        begin
            slow <= (i == 5);
            wr(`EBTC_GEN_CTRL_OFFSET, cfg_gen[i]);
            wr(`EBTC_TIM_CTRL_OFFSET, cfg_tim[i]);
            a = 16'hA530 + 16'(i) * 16'h0111;
            d = 16'h3C00 + 16'(i) * 16'h1111;
            access(1'h1, a, d);
            chk({16'h0000, lat_addr}, {16'h0000, a});
            access(1'h0, a, 16'h0000);
            access(1'h0, a, 16'h0000);
            rd(`EBTC_CMD_DATA_OFFSET, v);
            chk(v, cfg_gen[i][1] ? {16'h0000, d} : {24'h000000, d[7:0]});
            chk({31'h0, cs_lvl}, {31'h0, (i == 0 || i > 5)});
        end
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd_chk(`EBTC_TIM_CTRL_OFFSET, 32'h0000_0000);
        finish_test();
    end
endmodule
